// [verilog/mode_ctl_pkg.sv]
`default_nettype none
package mode_ctl_pkg;
  // ---------------------------------------------------------------
  // timing, in own units and in 100 MHz cycles
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BOOT_MS       = 1750;
  localparam int unsigned GYRO_WAKE_MS  = 60;
  localparam int unsigned ACCEL_WAKE_MS = 3;
  localparam int unsigned MAG_WAKE_MS   = 12;
  localparam int unsigned OFF_STEP_US   = 40;
  localparam int unsigned SETTLE_PERIODS = 3;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned BOOT_CYC      = BOOT_MS * CYC_PER_MS;
  localparam int unsigned GYRO_WAKE_CYC = GYRO_WAKE_MS * CYC_PER_MS;
  localparam int unsigned ACCEL_WAKE_CYC = ACCEL_WAKE_MS * CYC_PER_MS;
  localparam int unsigned MAG_WAKE_CYC  = MAG_WAKE_MS * CYC_PER_MS;
  localparam int unsigned OFF_STEP_CYC  = OFF_STEP_US * (CLK_HZ / 1_000_000);
  // ---------------------------------------------------------------
  // rate field patterns
  // ---------------------------------------------------------------
  localparam logic [3:0] RATE_DEFAULT   = 4'h0;
  localparam logic [1:0] RATE_LP_TOP    = 2'h3;
  localparam int unsigned RATE_W        = 4;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       accel_on;
    logic       gyro_on;
    logic       magnetometer_on;
    logic       fusion_on;
    logic       gyro_snooze;
    logic       poll_on_request;
    logic [3:0] accel_rate_select;
  } sensor_cfg_t;
  typedef enum logic [3:0] {
    MODE_DEFAULT, MODE_LOW_POWER, MODE_ACCEL, MODE_ACCEL_LP,
    MODE_GYRO_SNOOZE, MODE_GYRO, MODE_MAG, MODE_COMPASS, MODE_IMU,
    MODE_NINE_AXIS, MODE_ACCEL_SNZ, MODE_ACCEL_MAG_SNZ,
    MODE_FUSION6, MODE_FUSION9, MODE_ON_DEMAND
  } op_mode_t;
  typedef struct packed {
    logic accel_data;
    logic gyro_data;
    logic mag_data;
    logic fusion_data;
    logic gyro_drive;
    logic slow_clock;
  } out_sel_t;
endpackage : mode_ctl_pkg
`default_nettype wire

// [verilog/rate_tick.sv]
`timescale 1ns/1ps
`default_nettype none
// one-cycle pulse every period_cyc cycles; restarts on i_restart
module rate_tick #(
  parameter int unsigned CNT_W = 24
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_restart,
  input  wire logic [CNT_W-1:0] i_period_cyc,
  output logic                  o_tick
);
  logic [CNT_W-1:0] count;           // cycles in current period
  // elaboration guard: a one-bit counter cannot hold a period
  if (CNT_W < 2) begin : g_bad_width
    $error("rate_tick: CNT_W too small");
  end
  // -----------------------------------------------------------------
  // divider
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_restart) begin
      count <= '0;
    end else if (count + 1'b1 >= i_period_cyc) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end
  assign o_tick = i_rst_n && !i_restart && (count + 1'b1 >= i_period_cyc);
endmodule : rate_tick
`default_nettype wire

// [verilog/sensor_operating_mode_control.sv]
`timescale 1ns/1ps
`default_nettype none
module sensor_operating_mode_control #(
  parameter int unsigned BOOT_CYCLES  = mode_ctl_pkg::BOOT_CYC,
  parameter int unsigned GYRO_CYCLES  = mode_ctl_pkg::GYRO_WAKE_CYC,
  parameter int unsigned ACCEL_CYCLES = mode_ctl_pkg::ACCEL_WAKE_CYC,
  parameter int unsigned MAG_CYCLES   = mode_ctl_pkg::MAG_WAKE_CYC,
  parameter int unsigned CNT_W        = 28
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_soft_reset,
  input  wire logic                      i_cfg_write,
  input  wire mode_ctl_pkg::sensor_cfg_t i_cfg,
  input  wire logic [23:0]               i_odr_period_cyc,
  input  wire logic                      i_poll_req,
  output logic                           o_booted,
  output mode_ctl_pkg::op_mode_t         o_mode,
  output mode_ctl_pkg::out_sel_t         o_out_sel,
  output logic                           o_data_ready_pin,
  output logic                           o_data_valid,
  output logic                           o_settled,
  output logic                           o_sensors_off,
  output logic                           o_poll_ack
);
  import mode_ctl_pkg::*;

  // elaboration guard: the boot count must fit the phase timer
  if (CNT_W < 24 || BOOT_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_width
    $error("sensor_operating_mode_control: CNT_W too narrow");
  end

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_BOOT, ST_IDLE, ST_WAKE, ST_SETTLE, ST_RUN, ST_SHUTDOWN, ST_OFFSTEP
  } seq_t;
  seq_t          seq;              // sequencer state
  sensor_cfg_t   cfg;              // held configuration
  logic [CNT_W-1:0] timer;         // countdown for current phase
  logic [1:0]    periods;          // rate periods counted
  logic          odr_tick;         // one pulse per rate period
  logic          tick_restart;     // realign divider to phase start
  op_mode_t      next_mode;        // decoded mode
  out_sel_t      next_sel;         // decoded output routing
  logic [CNT_W-1:0] wake_cyc;      // wake time of decoded mode
  logic          lp_rate;          // rate field is 11xx
  logic          any_sensor;       // some sensor powered

  assign lp_rate    = cfg.accel_rate_select[3:2] == RATE_LP_TOP;
  assign any_sensor = cfg.accel_on | cfg.gyro_on | cfg.magnetometer_on;

  // -----------------------------------------------------------------
  // mode decode from held fields
  // -----------------------------------------------------------------
  always_comb begin
    next_sel = '0;
    next_sel.slow_clock = lp_rate;
    if (!any_sensor) begin
      next_mode = lp_rate ? MODE_LOW_POWER : MODE_DEFAULT;
    end else if (cfg.accel_on && cfg.gyro_on && cfg.fusion_on &&
                 cfg.poll_on_request) begin
      next_mode = MODE_ON_DEMAND;
      next_sel.fusion_data = 1'b1;
      next_sel.gyro_drive  = 1'b1;
      next_sel.mag_data    = cfg.magnetometer_on;
    end else if (cfg.accel_on && cfg.gyro_on && cfg.fusion_on &&
                 cfg.magnetometer_on) begin
      next_mode = MODE_FUSION9;
      next_sel.fusion_data = 1'b1;
      next_sel.mag_data    = 1'b1;
      next_sel.gyro_drive  = 1'b1;
    end else if (cfg.accel_on && cfg.gyro_on && cfg.fusion_on &&
                 !cfg.accel_rate_select[3]) begin
      next_mode = MODE_FUSION6;
      next_sel.fusion_data = 1'b1;
      next_sel.gyro_drive  = 1'b1;
    end else if (cfg.accel_on && cfg.gyro_on && cfg.gyro_snooze) begin
      next_mode = cfg.magnetometer_on ? MODE_ACCEL_MAG_SNZ
                                      : MODE_ACCEL_SNZ;
      next_sel.accel_data = 1'b1;
      next_sel.mag_data   = cfg.magnetometer_on;
      next_sel.gyro_drive = 1'b1;
    end else if (cfg.accel_on && cfg.gyro_on && !lp_rate) begin
      next_mode = cfg.magnetometer_on ? MODE_NINE_AXIS
                                      : MODE_IMU;
      next_sel.accel_data = 1'b1;
      next_sel.gyro_data  = 1'b1;
      next_sel.gyro_drive = 1'b1;
      next_sel.mag_data   = cfg.magnetometer_on;
    end else if (cfg.accel_on && !cfg.gyro_on && cfg.magnetometer_on &&
                 !lp_rate) begin
      next_mode = MODE_COMPASS;
      next_sel.accel_data = 1'b1;
      next_sel.mag_data   = 1'b1;
    end else if (!cfg.accel_on && !cfg.gyro_on) begin
      next_mode = MODE_MAG;
      next_sel.mag_data = 1'b1;
    end else if (cfg.accel_on && !cfg.gyro_on) begin
      next_mode = lp_rate ? MODE_ACCEL_LP : MODE_ACCEL;
      next_sel.accel_data = 1'b1;
    end else begin
      // gyro without accel, snoozed or sensing, or accel and gyro unsnoozed at an 11xx rate, sensing
      next_mode = cfg.gyro_snooze ? MODE_GYRO_SNOOZE : MODE_GYRO;
      next_sel.gyro_data  = !cfg.gyro_snooze;
      next_sel.gyro_drive = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // wake time: slowest powered sensor dominates
  // -----------------------------------------------------------------
  always_comb begin
    wake_cyc = CNT_W'(1);
    if (cfg.gyro_on) begin
      wake_cyc = CNT_W'(GYRO_CYCLES);
    end else if (cfg.magnetometer_on) begin
      wake_cyc = CNT_W'(MAG_CYCLES);
    end else if (cfg.accel_on) begin
      wake_cyc = CNT_W'(ACCEL_CYCLES);
    end
  end

  // -----------------------------------------------------------------
  // rate period divider
  // -----------------------------------------------------------------
  rate_tick #(
    .CNT_W        (24)
  ) u_rate_tick (
    .i_ref_clk    (i_ref_clk),
    .i_rst_n      (i_rst_n),
    .i_restart    (tick_restart),
    .i_period_cyc (i_odr_period_cyc),
    .o_tick       (odr_tick)
  );

  // -----------------------------------------------------------------
  // configuration capture; soft reset returns defaults
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_soft_reset) begin
      cfg <= '0;
    end else if (i_cfg_write) begin
      cfg <= i_cfg;
    end
  end

  // restart the divider whenever a timed phase starts
  assign tick_restart = i_cfg_write || (seq == ST_WAKE && timer == '0);

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_soft_reset) begin
      seq     <= ST_BOOT;
      timer   <= CNT_W'(BOOT_CYCLES - 1);
      periods <= '0;
    end else if (i_cfg_write && seq != ST_BOOT) begin
      // any field write restarts timing for the new mode
      periods <= '0;
      if (i_cfg.accel_on | i_cfg.gyro_on | i_cfg.magnetometer_on) begin
        seq   <= ST_WAKE;
        timer <= '0;
      end else if (any_sensor) begin
        seq   <= ST_SHUTDOWN;
        timer <= '0;
      end else begin
        seq   <= ST_OFFSTEP;
        timer <= CNT_W'(OFF_STEP_CYC - 1);
      end
    end else begin
      case (seq)
        ST_BOOT: begin
          if (timer == '0) begin
            seq <= ST_IDLE;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ST_WAKE: begin
          // timer loaded one cycle after the write
          if (timer == '0) begin
            seq   <= ST_SETTLE;
            timer <= wake_cyc - 1'b1;
          end
        end
        ST_SETTLE: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else if (odr_tick) begin
            if (periods == 2'(SETTLE_PERIODS - 1)) begin
              seq <= ST_RUN;
            end
            periods <= periods + 1'b1;
          end
        end
        ST_SHUTDOWN: begin
          // finish on the first rate boundary after the write
          if (odr_tick) begin
            seq <= ST_IDLE;
          end
        end
        ST_OFFSTEP: begin
          if (timer == '0) begin
            seq <= ST_IDLE;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // data-ready pin: first edge opens the wake, data one wake later
  // -----------------------------------------------------------------
  logic pin_q;                     // registered pin level
  logic valid_q;                   // data present in outputs
  logic data_live;                 // wake over, outputs refreshed
  // no rate pulses before data, so the host never latches stale words
  assign data_live = (seq == ST_SETTLE && timer == '0) || seq == ST_RUN;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_soft_reset) begin
      pin_q   <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      pin_q   <= seq == ST_WAKE || (data_live && odr_tick);
      valid_q <= data_live;
    end
  end

  // -----------------------------------------------------------------
  // on-demand poll acknowledge
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_soft_reset) begin
      o_poll_ack <= 1'b0;
    end else begin
      o_poll_ack <= i_poll_req && seq == ST_RUN &&
                    o_mode == MODE_ON_DEMAND;
    end
  end

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_soft_reset) begin
      o_mode    <= MODE_DEFAULT;
      o_out_sel <= '0;
    end else if (seq == ST_BOOT) begin
      o_mode    <= MODE_DEFAULT;
      o_out_sel <= '0;
    end else begin
      o_mode    <= next_mode;
      o_out_sel <= (seq == ST_SHUTDOWN || seq == ST_OFFSTEP)
                   ? out_sel_t'({5'h0, next_sel.slow_clock}) : next_sel;
    end
  end

  assign o_booted         = seq != ST_BOOT;
  assign o_data_ready_pin = pin_q;
  assign o_data_valid     = valid_q;
  assign o_settled        = seq == ST_RUN;
  // sensors count as off only once the shutdown period has run out
  assign o_sensors_off    = !any_sensor && seq != ST_SHUTDOWN;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence settle_done_s;
    seq == ST_SETTLE && timer == '0 && odr_tick &&
    periods == 2'(SETTLE_PERIODS - 1);
  endsequence
  boot_default_mode_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n) seq == ST_BOOT |=> o_mode == MODE_DEFAULT)
    else $error("mode left default during boot");
  settle_to_run_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n || i_cfg_write || i_soft_reset)
    settle_done_s |=> o_settled)
    else $error("settle did not reach run");
  run_needs_three_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n)
    $rose(o_settled) |-> $past(periods) == 2'(SETTLE_PERIODS - 1))
    else $error("run entered early");
  soft_reset_boot_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n) i_soft_reset |=> !o_booted)
    else $error("soft reset did not reboot");
  mag_only_mode_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n || i_soft_reset)
    (o_booted && !cfg.accel_on && !cfg.gyro_on && cfg.magnetometer_on)
    |=> o_mode == MODE_MAG)
    else $error("mag only not decoded");
  snooze_no_gyro_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n) o_mode == MODE_ACCEL_SNZ |->
    !o_out_sel.gyro_data && o_out_sel.accel_data)
    else $error("gyro data in snooze");
  poll_ack_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n) o_poll_ack |-> $past(i_poll_req))
    else $error("poll ack without request");
  shutdown_bound_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n || i_cfg_write || i_soft_reset)
    (seq == ST_SHUTDOWN && odr_tick) |=> seq == ST_IDLE)
    else $error("shutdown overran");
  fusion_rate_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n) o_mode == MODE_FUSION6 |->
    o_out_sel.fusion_data && !o_out_sel.accel_data)
    else $error("fusion6 output wrong");
  wake_pin_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_n || i_soft_reset)
    seq == ST_WAKE |=> o_data_ready_pin && !o_data_valid)
    else $error("wake start not flagged on pin");
endmodule : sensor_operating_mode_control
`default_nettype wire

// [dv/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// host side: config writes, polling and software reset
// ---------------------------------------------------------------
module host_model (
  input  wire logic                 i_ref_clk,
  output logic                      o_cfg_write,
  output mode_ctl_pkg::sensor_cfg_t o_cfg,
  output logic [23:0]               o_odr_period_cyc,
  output logic                      o_poll_req,
  output logic                      o_soft_reset
);
  import mode_ctl_pkg::*;

  // idle values from time zero, nothing requested
  initial begin
    o_cfg_write      = 1'b0;
    o_cfg            = '0;
    o_odr_period_cyc = 24'h00_0004;
    o_poll_req       = 1'b0;
    o_soft_reset     = 1'b0;
  end

  // one-cycle write pulse, rate period changes with the fields
  task automatic write_cfg(input sensor_cfg_t c, input logic [23:0] per);
    @(posedge i_ref_clk);
    o_cfg            <= c;
    o_odr_period_cyc <= per;
    o_cfg_write      <= 1'b1;
    @(posedge i_ref_clk);
    o_cfg_write      <= 1'b0;
  endtask : write_cfg

  // asynchronous poll of fused results, one request pulse
  task automatic poll();
    @(posedge i_ref_clk);
    o_poll_req <= 1'b1;
    @(posedge i_ref_clk);
    o_poll_req <= 1'b0;
  endtask : poll

  // only used when a full reboot is wanted
  task automatic soft_reset();
    @(posedge i_ref_clk);
    o_soft_reset <= 1'b1;
    @(posedge i_ref_clk);
    o_soft_reset <= 1'b0;
  endtask : soft_reset
endmodule : host_model
`default_nettype wire

// [dv/sensor_operating_mode_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sensor_operating_mode_control_tb;
  import mode_ctl_pkg::*;
  // ---------------------------------------------------------------
  // short counts so the run stays brief
  // ---------------------------------------------------------------
  localparam int BOOT_N = 50, GYRO_N = 20, ACCEL_N = 5, MAG_N = 10;
  logic        i_ref_clk, i_rst_n, soft_rst, cfg_wr, poll_req;
  sensor_cfg_t cfg;
  logic [23:0] odr_per;
  logic        o_booted, o_data_ready_pin, o_data_valid, o_settled;
  logic        o_sensors_off, o_poll_ack;
  op_mode_t    o_mode;
  out_sel_t    o_out_sel;
  int          err_count, tests_run;
  logic [15:0] lfsr;        // random source, fixed start
  logic [9:0]  corner [16]; // one config per mode, then off again
  initial corner = '{10'h000, 10'h00c, 10'h203, 10'h20d, 10'h121,
    10'h102, 10'h083, 10'h284, 10'h305, 10'h386, 10'h327, 10'h3a8,
    10'h342, 10'h3c1, 10'h353, 10'h000};

  initial i_ref_clk = 1'b0;
  always #5 i_ref_clk = ~i_ref_clk;

  host_model host_model_i (.i_ref_clk(i_ref_clk), .o_cfg_write(cfg_wr),
    .o_cfg(cfg), .o_odr_period_cyc(odr_per), .o_poll_req(poll_req),
    .o_soft_reset(soft_rst));
  sensor_operating_mode_control #(.BOOT_CYCLES(BOOT_N),
    .GYRO_CYCLES(GYRO_N), .ACCEL_CYCLES(ACCEL_N), .MAG_CYCLES(MAG_N))
  sensor_operating_mode_control_i (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_soft_reset(soft_rst), .i_cfg_write(cfg_wr),
    .i_cfg(cfg), .i_odr_period_cyc(odr_per), .i_poll_req(poll_req),
    .o_booted(o_booted), .o_mode(o_mode), .o_out_sel(o_out_sel),
    .o_data_ready_pin(o_data_ready_pin), .o_data_valid(o_data_valid),
    .o_settled(o_settled), .o_sensors_off(o_sensors_off),
    .o_poll_ack(o_poll_ack));
  // ---------------------------------------------------------------
  // expectation functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // keeps random configs inside combinations that have a defined mode
  function automatic sensor_cfg_t fix_cfg(input logic [15:0] r);
    sensor_cfg_t c;
    c = r[9:0];
    if (c.gyro_on && c.magnetometer_on) c.accel_on = 1'b1;
    if (c.fusion_on) begin
      {c.accel_on, c.gyro_on} = 2'b11;
      c.accel_rate_select[3] = 1'b0;
    end else c.poll_on_request = 1'b0;
    if (!c.gyro_on) c.gyro_snooze = 1'b0;
    if (c.accel_on || c.gyro_on || c.magnetometer_on)
      c.accel_rate_select[2] = 1'b0;
    return c;
  endfunction : fix_cfg

  function automatic op_mode_t exp_mode(input sensor_cfg_t c);
    logic lp, s;
    lp = (c.accel_rate_select[3:2] == RATE_LP_TOP);
    s  = c.gyro_snooze;
    if (c.fusion_on && c.accel_on && c.gyro_on) begin
      if (c.poll_on_request) return MODE_ON_DEMAND;
      return c.magnetometer_on ? MODE_FUSION9 : MODE_FUSION6;
    end
    case ({c.accel_on, c.gyro_on, c.magnetometer_on})
      3'b000:  return lp ? MODE_LOW_POWER : MODE_DEFAULT;
      3'b001:  return MODE_MAG;
      3'b010:  return s ? MODE_GYRO_SNOOZE : MODE_GYRO;
      3'b100:  return lp ? MODE_ACCEL_LP : MODE_ACCEL;
      3'b101:  return MODE_COMPASS;
      3'b110:  return s ? MODE_ACCEL_SNZ : MODE_IMU;
      default: return s ? MODE_ACCEL_MAG_SNZ : MODE_NINE_AXIS;
    endcase
  endfunction : exp_mode

  // slowest enabled sensor sets the wake time
  function automatic int wake_of(input sensor_cfg_t c);
    if (c.gyro_on) return GYRO_N;
    if (c.magnetometer_on) return MAG_N;
    return c.accel_on ? ACCEL_N : 0;
  endfunction : wake_of
  // ---------------------------------------------------------------
  // checking and scenario tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic boot_check();
    int n;
    n = 0;
    #1;
    check("reset_mode", o_mode, MODE_DEFAULT);
    check("reset_off", o_sensors_off, 1);
    while (o_booted !== 1'b1 && n < BOOT_N + 10) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check("boot_time", 32'(n >= BOOT_N - 2 && n <= BOOT_N + 3), 1);
  endtask : boot_check

  task automatic poll_check(input logic exp);
    logic seen;
    seen = 1'b0;
    host_model_i.poll();
    repeat (3) begin
      #1;
      if (o_poll_ack === 1'b1) seen = 1'b1;
      @(posedge i_ref_clk);
    end
    check("poll_ack", 32'(seen), 32'(exp));
  endtask : poll_check

  // write one config, time the transition, then check the routing
  task automatic run_cfg(input sensor_cfg_t c, input logic [23:0] per);
    int n, w, lo, hi, pulses, tp, tv;
    logic prev_on;
    op_mode_t m;
    prev_on = (o_sensors_off === 1'b0);
    m = exp_mode(c);
    w = wake_of(c);
    n = 0;
    host_model_i.write_cfg(c, per);
    if (w > 0) begin
      lo = w + 2 * int'(per) - 2;
      hi = w + 3 * int'(per) + 4;
      tp = -1;
      tv = -1;
      // first pin edge and first valid data give the wake interval
      do begin
        @(posedge i_ref_clk);
        #1;
        n++;
        if (tp < 0 && o_data_ready_pin === 1'b1) tp = n;
        if (tv < 0 && o_data_valid === 1'b1) tv = n;
      end while (o_settled !== 1'b1 && n <= hi);
      check("wake_time", tv - tp, w);
      check("settle_time", 32'(n >= lo && n <= hi), 1);
      pulses = 0;
      repeat (2 * per) begin
        @(posedge i_ref_clk);
        #1;
        if (o_data_ready_pin === 1'b1) pulses++;
      end
      check("ready_pulses", pulses, 2);
      check("data_valid", o_data_valid, 1);
      check("sensors_off", o_sensors_off, 0);
    end else begin
      if (prev_on) begin
        hi = 2 * int'(per) + 4;
        do begin @(posedge i_ref_clk); #1; n++; end
        while (o_sensors_off !== 1'b1 && n <= hi);
        check("shutdown_time", 32'(n >= per - 1 && n <= hi), 1);
      end else begin
        repeat (OFF_STEP_CYC + 4) @(posedge i_ref_clk);
        #1;
      end
      check("off_data", o_out_sel[5:2], 0);
    end
    check("mode", o_mode, m);
    check("slow_clock", o_out_sel.slow_clock,
          32'(c.accel_rate_select[3:2] == RATE_LP_TOP));
    if (m inside {MODE_FUSION6, MODE_FUSION9, MODE_ON_DEMAND}) begin
      check("fusion_data", o_out_sel.fusion_data, 1);
      check("fusion_mag", o_out_sel.mag_data, c.magnetometer_on);
    end else if (w > 0)
      check("routing", o_out_sel[5:1], {c.accel_on,
            c.gyro_on & ~c.gyro_snooze, c.magnetometer_on, 1'b0,
            c.gyro_on});
    poll_check(m == MODE_ON_DEMAND);
  endtask : run_cfg

  task automatic finish_test();
    $display("counts: %0d mismatches in %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    err_count = 0;
    tests_run = 0;
    i_rst_n   = 1'b0;
    lfsr      = 16'hb084;
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    boot_check();
    foreach (corner[k]) run_cfg(sensor_cfg_t'(corner[k]), 24'h00_0004);
    // gyro wake cut short by an accel-only write
    host_model_i.write_cfg(sensor_cfg_t'(10'h386), 24'h00_0004);
    run_cfg(sensor_cfg_t'(10'h203), 24'h00_0004);
    repeat (30) begin
      lfsr = lfsr_next(lfsr);
      run_cfg(fix_cfg(lfsr), 24'(3 + lfsr[15:14]));
    end
    host_model_i.soft_reset();
    boot_check();
    run_cfg(sensor_cfg_t'(10'h305), 24'h00_0005);
    finish_test();
  end

  // run needs about 10k cycles, so this only trips on a hang
  initial begin
    repeat (90000) @(posedge i_ref_clk);
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    finish_test();
  end
endmodule : sensor_operating_mode_control_tb
`default_nettype wire
